// >>> shared/rtw_pkg.sv
package rtw_pkg;

    // clock rates, in kHz, used to derive the carrier-unit tick
    localparam int HCLK_KHZ = 25000;
    localparam int CARRIER_KHZ = 13560;
    // carrier periods in one fixed wait unit
    localparam int CARRIER_DIV = 16;
    localparam int UNIT_ACC_MOD = CARRIER_DIV * HCLK_KHZ;
    localparam int UNIT_ACC_W = 19;
    localparam logic [18:0] UNIT_ACC_ADD = 19'(CARRIER_KHZ);
    localparam logic [18:0] UNIT_ACC_TOP = 19'(UNIT_ACC_MOD);

    // register indexes; byte address is four times the index
    localparam int ADDR_LSB = 2;
    localparam int IDX_W = 8;
    localparam logic [7:0] IDX_BURST_LEN = 8'h30;
    localparam logic [7:0] IDX_WAIT_CTRL = 8'h31;
    localparam logic [7:0] IDX_WAIT_LOW = 8'h32;
    localparam logic [7:0] IDX_CONFIG = 8'h38;
    localparam logic [7:0] IDX_STATUS = 8'h39;

    // reset values
    localparam logic [7:0] BURST_LEN_RST = 8'h00;
    localparam logic [7:0] WAIT_CTRL_RST = 8'hC0;
    localparam logic [7:0] WAIT_LOW_RST = 8'h00;
    localparam int CFG_W = 18;
    localparam logic [17:0] CONFIG_RST = 18'h00076;
    // reserved bits 7 and 3 of the burst length register read zero
    localparam logic [7:0] BURST_LEN_MASK = 8'h77;

    // field positions
    localparam int FIELD_W = 3;
    localparam int SYM1_LSB = 4;
    localparam int SYM0_LSB = 0;
    localparam int WREF_BIT = 7;
    localparam int WUNIT_BIT = 6;
    localparam int WHIGH_LSB = 3;
    localparam int STOPG_LSB = 0;
    localparam int CFG_HALF_LSB = 0;
    localparam int CFG_HALF_W = 16;
    localparam int CFG_TYPEB_BIT = 16;
    localparam int CFG_LEVEL_BIT = 17;
    localparam int ST_WAIT_BIT = 0;
    localparam int ST_BURST_BIT = 1;
    localparam int ST_STOP_BIT = 2;
    localparam int ST_GUARD_BIT = 3;
    localparam int ST_REMAIN_LSB = 16;

    // widths of counters
    localparam int WAIT_W = 11;
    localparam int BURST_CNT_W = 10;
    localparam int TRAIL_CNT_W = 4;

    // burst length in bits for codes 0 to 7
    localparam logic [8:0] BURST_BITS [8] = '{
        9'h008, 9'h010, 9'h020, 9'h030, 9'h040, 9'h060, 9'h080, 9'h100};

    // requests and reference events from the transmit path
    typedef struct packed {
        logic tx_start_req; // level: data transmission wanted
        logic burst_req; // level: burst wanted
        logic burst_sym; // burst symbol: 1 or 0
        logic tx_data_end; // pulse: own sent data ended
        logic rx_data_end; // pulse: received data ended
        logic frame_end; // pulse: frame body done, trailer may follow
    } rtw_event_s;

    // timing outputs toward the modulator
    typedef struct packed {
        logic tx_start; // pulse: data transmission may start
        logic burst_active; // unmodulated subcarrier burst running
        logic burst_level; // level chosen for the burst
        logic stop_bit; // stop bit running
        logic guard_time; // extra guard time running
        logic trail_done; // pulse: trailer finished or skipped
        logic wait_pending; // minimum gap still running
    } rtw_tx_s;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_BURST,
        ST_TRAIL
    } rtw_state_e;

endpackage

// >>> core/rtw_unit_tick.sv
`timescale 1ns/1ps
module rtw_unit_tick import rtw_pkg::*; (
    input wire logic hclk, // system clock
    input wire logic hresetn, // async reset, active low
    input wire logic realign, // restart the half-bit grid
    input wire logic [15:0] half_cycles, // hclk cycles per half bit
    output logic carrier_tick, // one pulse per 16 carrier periods
    output logic half_tick // one pulse per half bit period
);

    typedef struct packed {
        logic [18:0] acc;
        logic [15:0] half_cnt;
        logic ctick;
        logic htick;
    } rtw_tick_s;

    rtw_tick_s q;
    rtw_tick_s n;

    // fractional accumulator and half-bit divider
    always_comb begin
        n = q;
        n.ctick = 1'b0;
        n.htick = 1'b0;
        if (q.acc + UNIT_ACC_ADD >= UNIT_ACC_TOP) begin
            n.acc = q.acc + UNIT_ACC_ADD - UNIT_ACC_TOP;
            n.ctick = 1'b1;
        end else begin
            n.acc = q.acc + UNIT_ACC_ADD;
        end
        if (realign) begin
            n.half_cnt = '0;
        end else if (q.half_cnt + 16'h0001 >= half_cycles) begin
            // a zero setting behaves as one cycle
            n.half_cnt = '0;
            n.htick = 1'b1;
        end else begin
            n.half_cnt = q.half_cnt + 16'h0001;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign carrier_tick = q.ctick;
    assign half_tick = q.htick;

endmodule // rtw_unit_tick

// >>> core/rtw_stop_guard.sv
`timescale 1ns/1ps
module rtw_stop_guard import rtw_pkg::*; (
    input wire logic hclk, // system clock
    input wire logic hresetn, // async reset, active low
    input wire logic start, // pulse: begin trailer
    input wire logic [2:0] code, // stop and guard length code
    input wire logic half_tick, // half bit period tick
    output logic stop_bit, // stop bit running
    output logic guard_time, // extra guard time running
    output logic done // pulse: trailer finished
);

    typedef struct packed {
        logic run;
        logic [2:0] code;
        logic [3:0] cnt;
        logic done;
    } rtw_sg_s;

    rtw_sg_s q;
    rtw_sg_s n;

    // one stop bit, then code-1 guard bits, each two half ticks
    always_comb begin
        n = q;
        n.done = 1'b0;
        if (start) begin
            n.code = code;
            n.cnt = {code, 1'b0};
            n.run = (code != 3'h0);
            n.done = (code == 3'h0);
        end else if (q.run && half_tick) begin
            n.cnt = q.cnt - 4'h1;
            if (q.cnt == 4'h1) begin
                n.run = 1'b0;
                n.done = 1'b1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    // first bit of the trailer is the stop bit
    assign stop_bit = q.run && (q.cnt > {q.code - 3'h1, 1'b0});
    assign guard_time = q.run && !stop_bit;
    assign done = q.done;

endmodule // rtw_stop_guard

// >>> core/rtw_timing.sv
// How it works
// - a burst request emits unmodulated subcarrier for the burst length, level set apart
// - symbol-one burst length comes from bits 6..4, codes give 8 to 256 bits
// - symbol-zero burst length comes from bits 2..0, same 8 to 256 bit table
// - wait starts at end of sent data, or end of received data when bit 7 set
// - wait unit is 16 carrier periods, or half a bit period when bit 6 set
// - eleven-bit wait value: low byte register plus control bits 5..3 on top
// - wait is least spacing from receive to send or between two sends
// - stop code: 0 nothing, 1 one stop bit, 2..7 stop bit plus 1..6 guards
// - stop bit and guard time only apply to Type B frames
`timescale 1ns/1ps
module rtw_timing import rtw_pkg::*; (
    input wire logic hclk, // bus and block clock
    input wire logic hresetn, // async reset, active low
    input wire logic hsel, // slave select
    input wire logic [31:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write when high
    input wire logic [2:0] hsize, // transfer size, word only
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready
    output logic hreadyout, // slave ready
    output logic hresp, // response, always okay
    output logic [31:0] hrdata, // read data
    input wire rtw_event_s ev, // requests and reference events
    output rtw_tx_s tx // timing outputs
);

    typedef struct packed {
        rtw_state_e fsm;
        logic [7:0] burst_len;
        logic [7:0] wait_ctrl;
        logic [7:0] wait_low;
        logic [CFG_W-1:0] cfg;
        logic dsel;
        logic dwrite;
        logic [IDX_W-1:0] didx;
        logic [31:0] rdata;
        logic [WAIT_W-1:0] wait_cnt;
        logic [BURST_CNT_W-1:0] burst_cnt;
        logic tx_start;
    } rtw_top_s;

    rtw_top_s q;
    rtw_top_s n;

    logic carrier_tick;
    logic half_tick;
    logic realign;
    logic trail_start;
    logic [2:0] trail_code;
    logic stop_bit;
    logic guard_time;
    logic trail_done;
    logic unit_tick;
    logic ref_event;
    logic [WAIT_W-1:0] wait_value;
    logic [2:0] burst_code;
    logic [8:0] burst_bits;
    logic go_ok;
    logic [31:0] status;

    // tick sources for both wait units and the bit grid
    rtw_unit_tick u_tick (
        .hclk(hclk),
        .hresetn(hresetn),
        .realign(realign),
        .half_cycles(q.cfg[CFG_HALF_LSB +: CFG_HALF_W]),
        .carrier_tick(carrier_tick),
        .half_tick(half_tick)
    );

    // stop bit and guard time sequencer
    rtw_stop_guard u_trail (
        .hclk(hclk),
        .hresetn(hresetn),
        .start(trail_start),
        .code(trail_code),
        .half_tick(half_tick),
        .stop_bit(stop_bit),
        .guard_time(guard_time),
        .done(trail_done)
    );

    assign wait_value = {q.wait_ctrl[WHIGH_LSB +: FIELD_W], q.wait_low};

    assign unit_tick = q.wait_ctrl[WUNIT_BIT] ? half_tick : carrier_tick;

    assign ref_event = q.wait_ctrl[WREF_BIT] ? ev.rx_data_end : ev.tx_data_end;

    // burst length field pick by symbol
    assign burst_code = ev.burst_sym ? q.burst_len[SYM1_LSB +: FIELD_W]
                                     : q.burst_len[SYM0_LSB +: FIELD_W];
    assign burst_bits = BURST_BITS[burst_code];

    // a start is allowed only once the gap counter has run out
    // the grant cycle itself grants nothing: the requester drops only after seeing it
    assign go_ok = (q.fsm == ST_IDLE) && (q.wait_cnt == '0) && !ref_event && !q.tx_start;

    // realign the bit grid when a burst begins
    assign realign = go_ok && ev.burst_req && !(trail_start && (trail_code != 3'h0));

    // trailer only for Type B; otherwise it is skipped at once
    assign trail_start = ev.frame_end && (q.fsm == ST_IDLE);
    assign trail_code = q.cfg[CFG_TYPEB_BIT] ? q.wait_ctrl[STOPG_LSB +: FIELD_W] : 3'h0;

    // status word from the block's own state
    always_comb begin
        status = '0;
        status[ST_WAIT_BIT] = (q.wait_cnt != '0);
        status[ST_BURST_BIT] = (q.fsm == ST_BURST);
        status[ST_STOP_BIT] = stop_bit;
        status[ST_GUARD_BIT] = guard_time;
        status[ST_REMAIN_LSB +: WAIT_W] = q.wait_cnt;
    end

    // register writes, bus phases, wait counter and sequencing
    always_comb begin
        n = q;
        n.tx_start = 1'b0;

        // data phase of a write stores the word
        if (q.dsel && q.dwrite) begin
            unique case (q.didx)
                IDX_BURST_LEN: begin
                    n.burst_len = hwdata[7:0] & BURST_LEN_MASK;
                end
                IDX_WAIT_CTRL: begin
                    n.wait_ctrl = hwdata[7:0];
                end
                IDX_WAIT_LOW: begin
                    n.wait_low = hwdata[7:0];
                end
                IDX_CONFIG: begin
                    n.cfg = hwdata[CFG_W-1:0];
                end
                default: begin
                end
            endcase
        end

        // address phase is latched for the next cycle
        n.dsel = hsel && htrans[1] && hready;
        n.dwrite = hwrite;
        n.didx = haddr[ADDR_LSB +: IDX_W];

        // load the gap at the reference event, count it down
        if (ref_event) begin
            n.wait_cnt = wait_value;
        end else if (unit_tick && (q.wait_cnt != '0)) begin
            n.wait_cnt = q.wait_cnt - 11'h001;
        end

        unique case (q.fsm)
            ST_IDLE: begin
                if (trail_start && (trail_code != 3'h0)) begin
                    n.fsm = ST_TRAIL;
                end else if (go_ok && ev.burst_req) begin
                    // burst of the chosen length in half ticks
                    n.fsm = ST_BURST;
                    n.burst_cnt = {1'b0, burst_bits} << 1;
                end else if (go_ok && ev.tx_start_req) begin
                    // grant a send only after the gap
                    n.tx_start = 1'b1;
                end
            end
            ST_BURST: begin
                if (half_tick) begin
                    n.burst_cnt = q.burst_cnt - 10'h001;
                    if (q.burst_cnt == 10'h001) begin
                        n.fsm = ST_IDLE;
                    end
                end
            end
            ST_TRAIL: begin
                // sequencer counts stop and guard bits
                if (trail_done) begin
                    n.fsm = ST_IDLE;
                end
            end
            default: begin
                n.fsm = ST_IDLE;
            end
        endcase

        // read data uses the values after this cycle's write
        if (n.dsel && !hwrite) begin
            unique case (n.didx)
                IDX_BURST_LEN: begin
                    n.rdata = 32'(n.burst_len);
                end
                IDX_WAIT_CTRL: begin
                    n.rdata = 32'(n.wait_ctrl);
                end
                IDX_WAIT_LOW: begin
                    n.rdata = 32'(n.wait_low);
                end
                IDX_CONFIG: begin
                    n.rdata = 32'(n.cfg);
                end
                IDX_STATUS: begin
                    n.rdata = status;
                end
                default: begin
                    n.rdata = '0;
                end
            endcase
        end
    end

    // state register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q.fsm <= ST_IDLE;
            q.burst_len <= BURST_LEN_RST;
            q.wait_ctrl <= WAIT_CTRL_RST;
            q.wait_low <= WAIT_LOW_RST;
            q.cfg <= CONFIG_RST;
            q.dsel <= 1'b0;
            q.dwrite <= 1'b0;
            q.didx <= '0;
            q.rdata <= '0;
            q.wait_cnt <= '0;
            q.burst_cnt <= '0;
            q.tx_start <= 1'b0;
        end else begin
            q <= n;
        end
    end

    // bus answers: no wait states, always okay
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = q.rdata;

    // outputs toward the modulator
    always_comb begin
        tx.tx_start = q.tx_start;
        tx.burst_active = (q.fsm == ST_BURST);
        // burst level from the control setting
        tx.burst_level = q.cfg[CFG_LEVEL_BIT];
        tx.stop_bit = stop_bit;
        tx.guard_time = guard_time;
        tx.trail_done = trail_done;
        tx.wait_pending = (q.wait_cnt != '0);
    end

endmodule // rtw_timing

// >>> dv/rtw_card_model.sv
`timescale 1ns/1ps
module rtw_card_model import rtw_pkg::*; (
    input wire logic hclk, // block clock
    input wire logic hresetn, // async reset, active low
    input wire rtw_tx_s tx, // timing outputs of the block
    input wire logic [7:0] resp_gap, // card answer delay in cycles
    output logic frame_end, // pulse: frame body sent
    output logic tx_data_end, // pulse: own send over
    output logic rx_data_end // pulse: card answer over
);
    logic [3:0] body_q;
    logic [7:0] resp_q;

    // fixed body after each start, block trailer, then the card answers after resp_gap
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            body_q <= 4'h0;
            resp_q <= 8'h00;
            frame_end <= 1'b0;
            tx_data_end <= 1'b0;
            rx_data_end <= 1'b0;
        end else begin
            body_q <= tx.tx_start ? 4'h8 : body_q - 4'(body_q != 4'h0);
            frame_end <= (body_q == 4'h1);
            tx_data_end <= tx.trail_done;
            resp_q <= tx.trail_done ? resp_gap : resp_q - 8'(resp_q != 8'h00);
            rx_data_end <= (resp_q == 8'h01);
        end
    end
endmodule // rtw_card_model

// >>> dv/rtw_timing_chk.sv
`timescale 1ns/1ps
module rtw_timing_chk import rtw_pkg::*; (
    input wire logic hclk, // block clock
    input wire logic hresetn, // async reset, active low
    input wire rtw_event_s ev, // requests and events
    input wire rtw_tx_s tx // timing outputs
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    // start only with a request, outside gap, burst and trailer
    start_after_gap_a: assert property (tx.tx_start |-> !$past(tx.wait_pending))
        else $error("start while gap running");
    start_has_req_a: assert property (tx.tx_start |-> $past(ev.tx_start_req))
        else $error("start without request");
    start_single_a: assert property (tx.tx_start |=> !tx.tx_start)
        else $error("start granted twice in a row");
    start_not_busy_a: assert property (
        tx.tx_start |-> !$past(tx.burst_active || tx.stop_bit || tx.guard_time))
        else $error("start during burst or trailer");
    // gap counter only loads at a reference event
    gap_loaded_a: assert property (
        $rose(tx.wait_pending) |-> $past(ev.tx_data_end || ev.rx_data_end))
        else $error("gap began without reference event");
    // burst follows its request and stands alone
    burst_cause_a: assert property (
        $rose(tx.burst_active) |-> $past(ev.burst_req) && !$past(tx.wait_pending))
        else $error("burst without request");
    burst_alone_a: assert property (tx.burst_active |-> !(tx.stop_bit || tx.guard_time))
        else $error("burst overlaps trailer");
    // stop bit first, guard times after, then done
    guard_after_stop_a: assert property ($rose(tx.guard_time) |-> $past(tx.stop_bit))
        else $error("guard without stop bit");
    stop_not_both_a: assert property (!(tx.stop_bit && tx.guard_time))
        else $error("stop and guard together");
    trail_end_a: assert property (
        $fell(tx.stop_bit || tx.guard_time) |-> ##[0:1] tx.trail_done)
        else $error("trailer ended without done");
endmodule // rtw_timing_chk

bind rtw_timing rtw_timing_chk chk_u (.hclk(hclk), .hresetn(hresetn), .ev(ev), .tx(tx));

// >>> dv/rtw_timing_test.sv
`timescale 1ns/1ps
module rtw_timing_test import rtw_pkg::*; ;
    localparam int H = 4;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hready, hreadyout, hresp;
    logic [31:0] hrdata, rd;
    logic req = 1'b0, breq = 1'b0, bsym = 1'b0;
    logic f_end, t_end, r_end;
    logic [7:0] resp_gap = 8'h28;
    rtw_event_s ev;
    rtw_tx_s tx;
    int fails = 0, tests_run = 0, n, s, g, e;
    int bl [8] = '{8, 16, 32, 48, 64, 96, 128, 256};

    always #20 hclk = ~hclk;
    assign hready = hreadyout;
    assign ev = {req, breq, bsym, t_end, r_end, f_end};

    rtw_timing dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ev(ev), .tx(tx));
    rtw_card_model card_u (.hclk(hclk), .hresetn(hresetn), .tx(tx), .resp_gap(resp_gap),
        .frame_end(f_end), .tx_data_end(t_end), .rx_data_end(r_end));

    // one single word transfer; read data lands in rd
    task automatic bus(input logic [7:0] idx, input logic w, input logic [31:0] wd);
        haddr <= {22'h0, idx, 2'h0};
        hwrite <= w;
        htrans <= 2'h2;
        hsel <= 1'b1;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
        tests_run++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            fails++;
            $display("CHECK FAILED at %0t got %h expected %h..%h", $time, got, lo, hi);
        end
    endtask

    function automatic logic hit(input int sel);
        case (sel)
            0: return tx.tx_start === 1'b1;
            1: return tx.burst_active === 1'b1;
            2: return tx.burst_active === 1'b0;
            3: return tx.trail_done === 1'b1;
            4: return t_end === 1'b1;
            default: return r_end === 1'b1;
        endcase
    endfunction

    // count cycles, stop bit cycles and guard cycles until the chosen signal shows
    task automatic upto(input int sel);
        n = 0;
        s = 0;
        g = 0;
        do begin
            @(posedge hclk);
            n++;
            s += int'(tx.stop_bit === 1'b1);
            g += int'(tx.guard_time === 1'b1);
        end while (!hit(sel) && n < 40000);
        if (!hit(sel)) begin
            fails++;
            $display("CHECK FAILED at %0t event %h got %h cycles", $time, sel, n);
        end
    endtask

    // one send with the given stop code, then the trailer is measured
    task automatic trail(input int c, input int se, input int ge);
        bus(IDX_WAIT_CTRL, 1'b1, 32'(c));
        req <= 1'b1;
        upto(0);
        req <= 1'b0;
        upto(3);
        chk(s, se ? H : 0, se ? 2 * H + 1 : 0);
        chk(g, ge - int'(ge != 0), ge + 1);
        upto(5);
    endtask

    // time from the reference event to the next permitted start
    task automatic gap(input logic [7:0] ctl, input logic [7:0] lo, input int rs, input int u);
        bus(IDX_WAIT_CTRL, 1'b1, {24'h0, ctl});
        bus(IDX_WAIT_LOW, 1'b1, {24'h0, lo});
        req <= 1'b1;
        upto(0);
        req <= 1'b0;
        upto(rs);
        req <= 1'b1;
        // gap just loaded: full value and pending flag in the status word
        bus(IDX_STATUS, 1'b0, 32'h0);
        e = (32'({ctl[5:3], lo}) << ST_REMAIN_LSB) | 32'h1;
        chk(rd, e, e);
        upto(0);
        req <= 1'b0;
        chk(n, u - 30, u + 4);
        upto(5);
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        // reset values, reserved bits, unmapped place
        bus(IDX_WAIT_CTRL, 1'b0, 32'h0);
        chk(rd, 32'hC0, 32'hC0);
        chk(32'(hresp), 32'h0, 32'h0);
        bus(IDX_BURST_LEN, 1'b1, 32'hFF);
        bus(IDX_BURST_LEN, 1'b0, 32'h0);
        chk(rd, 32'h77, 32'h77);
        bus(8'h3F, 1'b1, 32'hFF);
        bus(8'h3F, 1'b0, 32'h0);
        chk(rd, 32'h0, 32'h0);
        $display("test registers done");
        // odd burst codes 1, 3, 5 and 7, symbol one and zero fields set apart
        bus(IDX_CONFIG, 1'b1, 32'h30004);
        for (int c = 0; c < 8; c++) begin
            bus(IDX_BURST_LEN, 1'b1, 32'((c << 4) | (7 - c)));
            bsym <= c[0];
            e = c[0] ? c : 7 - c;
            breq <= 1'b1;
            upto(1);
            breq <= 1'b0;
            chk(tx.burst_level, 1'b1, 1'b1);
            upto(2);
            chk(n, 2 * bl[e] * H - H, 2 * bl[e] * H + H);
        end
        $display("test burst done");
        // every stop code with Type B, then Type B off
        for (int c = 0; c < 8; c++) begin
            trail(c, c > 0, c > 1 ? (c - 1) * 2 * H : 0);
        end
        bus(IDX_CONFIG, 1'b1, 32'h20004);
        trail(7, 0, 0);
        $display("test trailer done");
        // gap from own send, from received data, in carrier units
        gap(8'h60, 8'h03, 4, 1027 * H + 26);
        gap(8'hC8, 8'h05, 5, 261 * H + 26);
        resp_gap <= 8'h03;
        gap(8'h00, 8'h14, 4, 590);
        $display("test gap done");
        wrap_up();
    end

    // watchdog well beyond the expected run
    initial begin
        #3000000;
        fails++;
        wrap_up();
    end
endmodule // rtw_timing_test
